// ### rtl/wsc_params.svh
/*
  Constants of the watchdog and sleep/wake controller: register indices,
  bit positions, reset values, timing figures and serial programming codes.
  Assumes it is included by the package and the test bench by bare name.
*/
`ifndef WSC_PARAMS_SVH
`define WSC_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define WSC_IDX_STATUS    32'h0000_0003
`define WSC_IDX_OPTION    32'h0000_0081
`define WSC_IDX_CONFIG    32'h0000_2007
`define WSC_STATUS_PD     3
`define WSC_STATUS_TO     4
`define WSC_OPT_PSA       3
`define WSC_CFG_WATCHDOG_ENABLE_FUSE      2
`define WSC_OPTION_RST    8'hff
`define WSC_CONFIG_RST    14'h3fff
`define WSC_OSC_RC_MODE   2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define WSC_WDT_PERIOD_US 18000
`define WSC_WDT_OSC_KHZ   1000
`define WSC_OST_CYCLES    10'h3ff
`define WSC_IRQ_VECTOR    14'h0004

// ****************************************************************
// Pin synchroniser lanes and idle levels
// ****************************************************************
`define WSC_PIN_WDT_OSC   0
`define WSC_PIN_MASTER_CLEAR_PIN_N    1
`define WSC_PIN_HV        2
`define WSC_PIN_PCLK      3
`define WSC_PIN_PDATA     4
`define WSC_PIN_IDLE      5'h02

// ****************************************************************
// Serial programming
// ****************************************************************
`define WSC_CMD_LOAD_CFG  6'h00
`define WSC_CMD_LOAD      6'h02
`define WSC_CMD_READ      6'h04
`define WSC_CMD_INC       6'h06
`define WSC_CMD_BITS      5'h06
`define WSC_DATA_BITS     5'h0e
`define WSC_ID_BASE       14'h2000
`define WSC_CFG_ADDR      14'h2007

`endif

// ### rtl/wsc_pkg.sv
/*
  Types of the watchdog and sleep/wake controller: bus carriers, core
  carriers, state enumerations and the whole-state struct.
  Assumes wsc_params.svh is on the include path.
*/
`include "wsc_params.svh"

package wsc_pkg;

  typedef enum logic [1:0] {WSC_RUN, WSC_SLEEP, WSC_OST} wsc_state_e;
  typedef enum logic [1:0] {WSC_P_CMD, WSC_P_LOAD, WSC_P_READ} wsc_prog_e;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } wsc_ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } wsc_ahb_rsp_s;

  typedef struct packed {
    logic watchdog_clear_instruction;
    logic sleep_instr;
    logic global_irq_enable;
    logic ext_irq_pending;
    logic second_timer_irq;
    logic second_timer_async;
    logic converter_irq;
    logic converter_rc_clock;
  } wsc_core_in_s;

  typedef struct packed {
    logic core_run;
    logic main_osc_enable;
    logic io_hold;
    logic device_reset;
    logic watchdog_reset;
    logic wake;
    logic vector_after_next;
    logic prefetch_next;
    logic prog_mode;
  } wsc_core_out_s;

  typedef struct packed {
    logic [4:0]        s1;
    logic [4:0]        s2;
    logic [4:0]        s3;
    logic [4:0]        filt;
    wsc_state_e        st;
    wsc_prog_e         pst;
    logic [14:0]       wdt_cnt;
    logic [7:0]        pre;
    logic [9:0]        ost;
    logic              timeout_flag;
    logic              powerdown_flag;
    logic              irq_wake;
    logic [7:0]        option;
    logic [13:0]       cfg;
    logic [3:0][13:0]  id;
    logic [13:0]       pc;
    logic [5:0]        cmd;
    logic [13:0]       sh;
    logic [4:0]        bits;
    logic              wr_pend;
    logic [31:0]       wr_addr;
    logic [7:0]        pad_out;
    logic [7:0]        pad_oe_n;
    logic              pdata_out;
    logic              pdata_oe_n;
    wsc_ahb_rsp_s      rsp;
    wsc_core_out_s     core;
  } wsc_state_s;

endpackage

// ### rtl/wsc_watchdog_ctrl.sv
/*
  Watchdog timer, sleep entry and wake-up control, ID locations and serial
  program/verify entry, with an AHB-Lite register slave.
  Assumes a single sys_clk domain; the watchdog RC oscillator and all pins
  arrive asynchronously and are synchronised here. The core supplies
  instruction strobes and already-enabled interrupt flags.
*/
`timescale 1ns/10ps
`default_nettype none

// Function
// - Watchdog runs from its own RC oscillator
// - Expiry while running gives watchdog reset
// - Expiry while asleep wakes, no reset
// - Cleared configuration enable bit disables watchdog
// - Unscaled time-out about 18 ms
// - Option register assigns prescaler, up to 1:128
// - Clear or sleep zeroes watchdog, and prescaler if assigned
// - Clear keeps prescaler assignment unchanged
// - Expiry clears timeout flag
// - Sleep clears powerdown, sets timeout, stops oscillator
// - Pins hold their drive state in sleep
// - Master clear resets; others wake and continue
// - Powerdown set at power-up, cleared by sleep
// - Only self-clocked peripherals wake from sleep
// - Sleep prefetches the next instruction
// - Enabled interrupt wakes; global enable picks vector
// - Pending interrupt makes sleep a no-operation
// - Late interrupt: sleep completes, then wakes
// - Crystal modes wait 1024 oscillator periods
// - ID locations only in program/verify mode
// - Low clock/data plus high level enters programming
// - Address zero, six-bit command, fourteen data bits
module wsc_watchdog_ctrl #(
  parameter int WDT_TIMEOUT_TICKS = `WSC_WDT_PERIOD_US * `WSC_WDT_OSC_KHZ / 1000
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  // AHB-Lite slave
  input  wire wsc_pkg::wsc_ahb_req_s  ahb_req,
  output var  wsc_pkg::wsc_ahb_rsp_s  ahb_rsp,
  // Processor core
  input  wire wsc_pkg::wsc_core_in_s  core_in,
  output var  wsc_pkg::wsc_core_out_s core_out,
  // Watchdog oscillator and device pins
  input  wire logic                   wdt_osc_clk,
  input  wire logic                   master_clear_pin_n,
  input  wire logic                   high_program_voltage_level,
  input  wire logic                   prog_clock_pin,
  input  wire logic                   prog_data_pin_in,
  output logic                        prog_data_pin_out,
  output logic                        prog_data_pin_oe_n,
  // Port pads, frozen in sleep
  input  wire logic [7:0]             port_out_req,
  input  wire logic [7:0]             port_oe_n_req,
  output logic [7:0]                  port_out,
  output logic [7:0]                  port_oe_n
);
  import wsc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  wsc_state_s state;
  wsc_state_s next_state;

  logic [4:0]  rise;
  logic        wdt_tick;
  logic        wdt_carry;
  logic        wdt_expire;
  logic        wdt_enabled;
  logic        irq_any;
  logic        irq_sleep;
  logic        sleep_take;
  logic        master_clear_pin_active;
  logic        addr_valid;
  logic [31:0] rd_addr;
  logic [7:0]  option_now;
  logic [7:0]  pre_mask;
  logic        id_hit;

  assign ahb_rsp            = state.rsp;
  assign core_out           = state.core;
  assign prog_data_pin_out  = state.pdata_out;
  assign prog_data_pin_oe_n = state.pdata_oe_n;
  assign port_out           = state.pad_out;
  assign port_oe_n          = state.pad_oe_n;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_state.core.watchdog_reset    = 1'b0;
    next_state.core.wake              = 1'b0;
    next_state.core.vector_after_next = 1'b0;
    next_state.core.prefetch_next     = 1'b0;

    // Pin synchronisers: a change counts once stages two and three agree
    next_state.s1 = {prog_data_pin_in, prog_clock_pin, high_program_voltage_level,
                     master_clear_pin_n, wdt_osc_clk};
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    for (int i = 0; i < 5; i++) begin
      if (state.s2[i] == state.s3[i]) begin
        next_state.filt[i] = state.s3[i];
      end
    end
    rise = next_state.filt & ~state.filt;

    master_clear_pin_active = ~state.filt[`WSC_PIN_MASTER_CLEAR_PIN_N];
    // The WDT only counts edges of its own oscillator, never sys_clk
    wdt_tick    = rise[`WSC_PIN_WDT_OSC];
    wdt_enabled = state.cfg[`WSC_CFG_WATCHDOG_ENABLE_FUSE];
    option_now  = state.option;

    // Prescaler ratio 1:2^ratio when assigned, else every tick carries
    pre_mask  = 8'((9'h001 << state.option[2:0]) - 9'h001);
    wdt_carry = ~state.option[`WSC_OPT_PSA] | ((state.pre & pre_mask) == pre_mask);
    // A clear in the expiry cycle wins, so no reset slips through
    wdt_expire = wdt_enabled & wdt_tick & wdt_carry &
                 ~(state.core.core_run & core_in.watchdog_clear_instruction) &
                 (state.wdt_cnt == 15'(WDT_TIMEOUT_TICKS - 1));

    irq_any = core_in.ext_irq_pending | core_in.second_timer_irq | core_in.converter_irq;
    // Q-clocked peripherals are frozen in sleep; only self-clocked ones count
    irq_sleep = core_in.ext_irq_pending |
                (core_in.second_timer_irq & core_in.second_timer_async) |
                (core_in.converter_irq & core_in.converter_rc_clock);
    sleep_take = (state.st == WSC_RUN) & state.core.core_run & core_in.sleep_instr & ~irq_any;

    // ----- Watchdog count
    if (wdt_enabled & wdt_tick) begin
      if (state.option[`WSC_OPT_PSA]) begin
        next_state.pre = wdt_carry ? 8'h00 : state.pre + 8'h01;
      end
      if (wdt_carry) begin
        next_state.wdt_cnt = wdt_expire ? 15'h0000 : state.wdt_cnt + 15'h0001;
      end
    end
    if (sleep_take | (state.core.core_run & core_in.watchdog_clear_instruction)) begin
      next_state.wdt_cnt = 15'h0000;
      if (state.option[`WSC_OPT_PSA]) begin
        next_state.pre = 8'h00;
      end
    end
    if (state.core.core_run & core_in.watchdog_clear_instruction & ~sleep_take) begin
      next_state.timeout_flag   = 1'b1;
      next_state.powerdown_flag = 1'b1;
    end

    // ----- Sleep and wake
    case (state.st)
      WSC_RUN: begin
        if (core_in.sleep_instr & state.core.core_run) begin
          next_state.core.prefetch_next = 1'b1;
        end
        if (sleep_take) begin
          next_state.st                   = WSC_SLEEP;
          next_state.powerdown_flag       = 1'b0;
          next_state.timeout_flag         = 1'b1;
          next_state.core.main_osc_enable = 1'b0;
          next_state.core.io_hold         = 1'b1;
          next_state.core.core_run        = 1'b0;
        end else if (wdt_expire) begin
          next_state.timeout_flag        = 1'b0;
          next_state.powerdown_flag      = 1'b1;
          next_state.option              = `WSC_OPTION_RST;
          next_state.core.watchdog_reset = 1'b1;
        end
      end
      WSC_SLEEP: begin
        // Sleep has completed by now, so a late interrupt still leaves
        // the count cleared and the flags updated before waking
        if (irq_sleep | wdt_expire) begin
          next_state.irq_wake             = irq_sleep;
          next_state.core.main_osc_enable = 1'b1;
          next_state.ost                  = 10'h000;
          if (wdt_expire) begin
            next_state.timeout_flag = 1'b0;
          end
          next_state.st = (state.cfg[1:0] == `WSC_OSC_RC_MODE) ? WSC_RUN : WSC_OST;
          if (state.cfg[1:0] == `WSC_OSC_RC_MODE) begin
            next_state.core.core_run          = 1'b1;
            next_state.core.io_hold           = 1'b0;
            next_state.core.wake              = 1'b1;
            next_state.core.vector_after_next = irq_sleep & core_in.global_irq_enable;
          end
        end
      end
      WSC_OST: begin
        next_state.ost = state.ost + 10'h001;
        if (state.ost == `WSC_OST_CYCLES) begin
          next_state.st                     = WSC_RUN;
          next_state.core.core_run          = 1'b1;
          next_state.core.io_hold           = 1'b0;
          next_state.core.wake              = 1'b1;
          next_state.core.vector_after_next = state.irq_wake & core_in.global_irq_enable;
        end
      end
      default: begin
        next_state.st = WSC_RUN;
      end
    endcase

    // Pads follow the core except while asleep
    if (~next_state.core.io_hold) begin
      next_state.pad_out  = port_out_req;
      next_state.pad_oe_n = port_oe_n_req;
    end

    // ----- Program/verify entry and exit
    if (rise[`WSC_PIN_HV] & ~state.filt[`WSC_PIN_PCLK] & ~state.filt[`WSC_PIN_PDATA]) begin
      next_state.core.prog_mode = 1'b1;
      next_state.pc             = 14'h0000;
      next_state.pst            = WSC_P_CMD;
      next_state.bits           = 5'h00;
    end else if (~state.filt[`WSC_PIN_HV]) begin
      next_state.core.prog_mode = 1'b0;
      next_state.pdata_oe_n     = 1'b1;
    end

    // ----- Serial command and data, LSB first on rising programming clock
    id_hit = (state.pc[13:2] == 12'(`WSC_ID_BASE >> 2));
    if (state.core.prog_mode & rise[`WSC_PIN_PCLK]) begin
      case (state.pst)
        WSC_P_CMD: begin
          next_state.cmd  = {state.filt[`WSC_PIN_PDATA], state.cmd[5:1]};
          next_state.bits = state.bits + 5'h01;
          if (state.bits == `WSC_CMD_BITS - 5'h01) begin
            next_state.bits = 5'h00;
            case (next_state.cmd)
              `WSC_CMD_LOAD_CFG: begin
                next_state.pc  = `WSC_ID_BASE;
                next_state.pst = WSC_P_LOAD;
              end
              `WSC_CMD_LOAD: begin
                next_state.pst = WSC_P_LOAD;
              end
              `WSC_CMD_READ: begin
                next_state.pst = WSC_P_READ;
                next_state.sh  = id_hit ? state.id[state.pc[1:0]] :
                                 (state.pc == `WSC_CFG_ADDR) ? state.cfg : 14'h0000;
              end
              `WSC_CMD_INC: begin
                next_state.pc = state.pc + 14'h0001;
              end
              default: begin
                next_state.pst = WSC_P_CMD;
              end
            endcase
          end
        end
        WSC_P_LOAD: begin
          next_state.sh   = {state.filt[`WSC_PIN_PDATA], state.sh[13:1]};
          next_state.bits = state.bits + 5'h01;
          if (state.bits == `WSC_DATA_BITS - 5'h01) begin
            next_state.bits = 5'h00;
            next_state.pst  = WSC_P_CMD;
            if (id_hit) begin
              next_state.id[state.pc[1:0]] = next_state.sh;
            end else if (state.pc == `WSC_CFG_ADDR) begin
              next_state.cfg = next_state.sh;
            end
          end
        end
        WSC_P_READ: begin
          next_state.pdata_out  = state.sh[0];
          next_state.pdata_oe_n = 1'b0;
          next_state.sh         = {1'b0, state.sh[13:1]};
          next_state.bits       = state.bits + 5'h01;
          if (state.bits == `WSC_DATA_BITS) begin
            next_state.bits       = 5'h00;
            next_state.pst        = WSC_P_CMD;
            next_state.pdata_oe_n = 1'b1;
          end
        end
        default: begin
          next_state.pst = WSC_P_CMD;
        end
      endcase
    end

    // ----- Master clear and program mode hold the core in reset
    next_state.core.device_reset = master_clear_pin_active | next_state.core.prog_mode;
    if (master_clear_pin_active | state.core.prog_mode) begin
      next_state.st                   = WSC_RUN;
      next_state.wdt_cnt              = 15'h0000;
      next_state.pre                  = 8'h00;
      next_state.option               = `WSC_OPTION_RST;
      next_state.core.core_run        = 1'b0;
      next_state.core.main_osc_enable = 1'b1;
      next_state.core.io_hold         = 1'b0;
      next_state.core.watchdog_reset  = 1'b0;
      next_state.core.wake            = 1'b0;
    end else if (state.core.device_reset) begin
      next_state.core.core_run = 1'b1;
    end

    // ----- AHB-Lite slave, zero wait states, always OKAY
    addr_valid = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
    rd_addr    = ahb_req.haddr;
    // Forward a write still in its data phase so back-to-back reads see it
    if (state.wr_pend & (state.wr_addr == (`WSC_IDX_OPTION << 2))) begin
      option_now = ahb_req.hwdata[7:0];
      if (~(master_clear_pin_active | state.core.prog_mode) & ~next_state.core.watchdog_reset) begin
        next_state.option = ahb_req.hwdata[7:0];
      end
    end
    next_state.wr_pend = addr_valid & ahb_req.hwrite;
    next_state.wr_addr = ahb_req.haddr;
    if (addr_valid & ~ahb_req.hwrite) begin
      if (rd_addr == (`WSC_IDX_STATUS << 2)) begin
        next_state.rsp.hrdata = 32'({state.timeout_flag, state.powerdown_flag, 3'h0});
      end else if (rd_addr == (`WSC_IDX_OPTION << 2)) begin
        next_state.rsp.hrdata = 32'(option_now);
      end else if (rd_addr == (`WSC_IDX_CONFIG << 2)) begin
        next_state.rsp.hrdata = 32'(state.cfg[7:0]);
      end else begin
        next_state.rsp.hrdata = 32'h0000_0000;
      end
    end
    next_state.rsp.hreadyout = 1'b1;
    next_state.rsp.hresp     = 1'b0;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state                      <= '0;
      state.s1                   <= `WSC_PIN_IDLE;
      state.s2                   <= `WSC_PIN_IDLE;
      state.s3                   <= `WSC_PIN_IDLE;
      state.filt                 <= `WSC_PIN_IDLE;
      state.timeout_flag         <= 1'b1;
      state.powerdown_flag       <= 1'b1;
      state.option               <= `WSC_OPTION_RST;
      state.cfg                  <= `WSC_CONFIG_RST;
      state.pad_oe_n             <= 8'hff;
      state.pdata_oe_n           <= 1'b1;
      state.rsp.hreadyout        <= 1'b1;
      state.core.core_run        <= 1'b1;
      state.core.main_osc_enable <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

endmodule

`default_nettype wire

// ### tb/wsc_core_model.sv
/*
  Core and serial programmer model: strobes, interrupt levels, watchdog
  RC oscillator, programming clock and the resolved programming data wire.
  Assumes sys_clk comes from the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module wsc_core_model
  import wsc_pkg::*;
(
  // Clock
  input  wire logic                  sys_clk,
  // Core side
  output var  wsc_pkg::wsc_core_in_s core_in,
  output logic                       wdt_osc_clk,
  // Programmer side
  output logic                       high_program_voltage_level,
  output logic                       prog_clock_pin,
  output logic                       prog_data_pin,
  input  wire logic                  dev_out,
  input  wire logic                  dev_oe_n
);
  logic pg;
  // Device wins the wire only while its driver is enabled
  assign prog_data_pin = dev_oe_n ? pg : dev_out;
  initial begin
    core_in = '0;
    high_program_voltage_level = 1'b0;
    prog_clock_pin = 1'b0;
    pg = 1'b0;
    wdt_osc_clk = 1'b0;
    // Free running, phase unrelated to sys_clk
    forever #163 wdt_osc_clk = ~wdt_osc_clk;
  end
  task automatic op(input logic [5:0] lv, input logic clr, input logic slp);
    @(posedge sys_clk);
    core_in <= {clr, slp, lv};
    @(posedge sys_clk);
    core_in <= {2'h0, lv};
  endtask
  task automatic enter(input logic on);
    @(posedge sys_clk);
    pg <= 1'b0;
    high_program_voltage_level <= on;
  endtask
  // LSB first; 8-cycle phases keep edges clear of the pin filter
  task automatic pbits(input logic [13:0] v, input int n, output logic [13:0] got);
    got = '0;
    for (int i = 0; i < n; i++) begin
      pg <= v[i];
      repeat (8) @(posedge sys_clk);
      prog_clock_pin <= 1'b1;
      repeat (8) @(posedge sys_clk);
      got[i] = prog_data_pin;
      prog_clock_pin <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/wsc_watchdog_ctrl_properties.sv
/*
  Checker of sleep entry, wake-up, pad freeze and watchdog pulses.
  Assumes it is bound into wsc_watchdog_ctrl running in RC oscillator mode.
*/
`timescale 1ns/10ps
`default_nettype none
module wsc_watchdog_ctrl_properties
  import wsc_pkg::*;
(
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   reset_n,
  // Core and pads
  input wire wsc_pkg::wsc_core_in_s  core_in,
  input wire wsc_pkg::wsc_core_out_s core_out,
  input wire logic [7:0]             port_out,
  input wire logic [7:0]             port_oe_n
);
  // ************
  // Properties
  // ************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic irq_any;
  logic sleep_go;
  assign irq_any  = core_in.ext_irq_pending | core_in.second_timer_irq | core_in.converter_irq;
  assign sleep_go = core_in.sleep_instr & core_out.core_run & ~core_out.device_reset;
  property p_sleep; sleep_go && !irq_any |=> !core_out.core_run && !core_out.main_osc_enable && core_out.io_hold; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not stop the core");
  property p_noop; sleep_go && irq_any |=> core_out.core_run; endproperty
  a_noop: assert property (p_noop) else $error("pending interrupt did not cancel sleep");
  property p_fetch; sleep_go |=> core_out.prefetch_next; endproperty
  a_fetch: assert property (p_fetch) else $error("no prefetch after sleep");
  property p_hold; core_out.io_hold |-> $stable(port_out) && $stable(port_oe_n); endproperty
  a_hold: assert property (p_hold) else $error("pads moved while held");
  property p_wake; core_out.wake |-> core_out.core_run && !core_out.io_hold ##1 !core_out.wake; endproperty
  a_wake: assert property (p_wake) else $error("bad wake pulse");
  property p_vector; core_out.vector_after_next |-> core_out.wake && $past(core_in.global_irq_enable); endproperty
  a_vector: assert property (p_vector) else $error("vector without global enable");
  property p_wdt; core_out.watchdog_reset |-> core_out.core_run ##1 !core_out.watchdog_reset; endproperty
  a_wdt: assert property (p_wdt) else $error("bad watchdog reset pulse");
  // Late interrupt must still wake, after the sleep has completed
  property p_late; $rose(core_in.ext_irq_pending) && core_out.io_hold |-> ##[1:3] core_out.wake; endproperty
  a_late: assert property (p_late) else $error("late interrupt did not wake");
  c_sleep: cover property (sleep_go && !irq_any);
  c_vector: cover property (core_out.vector_after_next);
  c_wdt: cover property (core_out.watchdog_reset);
endmodule
`default_nettype wire

// ### tb/wsc_watchdog_ctrl_test.sv
/*
  Self-checking bench of the watchdog and sleep/wake controller.
  Assumes the core model, the checker and the default configuration word.
*/
`timescale 1ns/10ps
`default_nettype none
`include "wsc_params.svh"
module wsc_watchdog_ctrl_test
  import wsc_pkg::*;
();
  localparam logic [31:0] addr_st = `WSC_IDX_STATUS << 2;
  localparam logic [31:0] addr_op = `WSC_IDX_OPTION << 2;
  localparam logic [31:0] addr_cf = `WSC_IDX_CONFIG << 2;
  logic          sys_clk;
  logic          reset_n;
  wsc_ahb_req_s  req;
  wsc_ahb_req_s  bus_req;
  wsc_ahb_rsp_s  rsp;
  wsc_core_in_s  core_in;
  wsc_core_out_s core_out;
  logic          osc, hv, pclk, pdat, dout, doe_n;
  logic [7:0]    po_req, poe_req, po, poe;
  logic [31:0]   rd;
  logic [13:0]   got;
  int            failures = 0;
  int            total_checks = 0;
  always_comb begin
    bus_req = req;
    bus_req.hready = rsp.hreadyout;
  end
  wsc_watchdog_ctrl #(.WDT_TIMEOUT_TICKS(8)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .ahb_req(bus_req), .ahb_rsp(rsp), .core_in(core_in),
    .core_out(core_out), .wdt_osc_clk(osc), .master_clear_pin_n(1'b1), .high_program_voltage_level(hv),
    .prog_clock_pin(pclk), .prog_data_pin_in(pdat), .prog_data_pin_out(dout), .prog_data_pin_oe_n(doe_n),
    .port_out_req(po_req), .port_oe_n_req(poe_req), .port_out(po), .port_oe_n(poe));
  wsc_core_model u_core (.sys_clk(sys_clk), .core_in(core_in), .wdt_osc_clk(osc),
    .high_program_voltage_level(hv), .prog_clock_pin(pclk), .prog_data_pin(pdat), .dev_out(dout), .dev_oe_n(doe_n));
  // ************
  // Tasks
  // ************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.hsel <= 1'b1;
    req.htrans <= 2'h2;
    req.haddr <= a;
    req.hwrite <= w;
    do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1);
    req.hsel <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= d;
    do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask
  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(n, rd, e);
  endtask
  task automatic wait_pulse(input logic wdt, input int n);
    for (int i = 0; i < n && (wdt ? core_out.watchdog_reset : core_out.wake) !== 1'b1; i++) begin
      @(posedge sys_clk);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Run takes about 900 cycles
  initial begin
    #(40 * 20000);
    failures++;
    end_of_test;
  end
  initial begin
    req = '0;
    req.hsize = 3'h2;
    po_req = 8'h5a;
    poe_req = 8'h0f;
    reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdc("status", addr_st, 32'h18);
    rdc("option", addr_op, 32'hff);
    bus(1'b1, addr_cf, 32'h0);
    rdc("config_ro", addr_cf, 32'hff);
    rdc("unmapped", 32'h100, 32'h0);
    rdc("id_hidden", 32'h2000 << 2, 32'h0);
    bus(1'b1, addr_op, 32'h0f);
    u_core.op(6'h00, 1'b1, 1'b0);
    rdc("option_kept", addr_op, 32'h0f);
    // Sleep with global enable, foreign timer flag, then pin interrupt
    u_core.op(6'h20, 1'b0, 1'b1);
    po_req <= 8'ha5;
    poe_req <= 8'hf0;
    u_core.op(6'h28, 1'b0, 1'b0);
    repeat (8) @(posedge sys_clk);
    chk("asleep", core_out.core_run, 1'b0);
    chk("osc_hold", {core_out.main_osc_enable, core_out.io_hold}, 2'h1);
    chk("pads", {po, poe}, 16'h5a0f);
    u_core.op(6'h30, 1'b0, 1'b0);
    wait_pulse(1'b0, 20);
    chk("vector", {core_out.wake, core_out.vector_after_next}, 2'h3);
    repeat (3) @(posedge sys_clk);
    chk("pads_free", {po, poe}, 16'ha5f0);
    rdc("status_irq", addr_st, 32'h10);
    u_core.op(6'h30, 1'b0, 1'b1);
    chk("noop_run", core_out.core_run, 1'b1);
    rdc("status_noop", addr_st, 32'h10);
    u_core.op(6'h00, 1'b1, 1'b0);
    rdc("status_clr", addr_st, 32'h18);
    // Interrupt just after sleep, global enable clear
    u_core.op(6'h00, 1'b0, 1'b1);
    u_core.op(6'h10, 1'b0, 1'b0);
    wait_pulse(1'b0, 20);
    chk("inline", {core_out.wake, core_out.vector_after_next}, 2'h2);
    rdc("status_late", addr_st, 32'h10);
    u_core.op(6'h00, 1'b0, 1'b0);
    // Watchdog expiry running, then asleep
    bus(1'b1, addr_op, 32'h08);
    wait_pulse(1'b1, 300);
    chk("wdt_reset", core_out.watchdog_reset, 1'b1);
    rdc("status_wdt", addr_st, 32'h08);
    rdc("option_rst", addr_op, 32'hff);
    bus(1'b1, addr_op, 32'h00);
    u_core.op(6'h00, 1'b0, 1'b1);
    wait_pulse(1'b0, 300);
    chk("wdt_wake", {core_out.wake, core_out.watchdog_reset}, 2'h2);
    rdc("status_wake", addr_st, 32'h00);
    // Program/verify: write then read back an ID word
    u_core.enter(1'b1);
    repeat (10) @(posedge sys_clk);
    chk("prog", {core_out.prog_mode, core_out.device_reset}, 2'h3);
    u_core.pbits(14'h0000, 6, got);
    u_core.pbits(14'h0005, 14, got);
    u_core.pbits(14'h0004, 6, got);
    u_core.pbits(14'h2aaa, 14, got);
    chk("id_word", got, 14'h0005);
    u_core.enter(1'b0);
    repeat (10) @(posedge sys_clk);
    end_of_test;
  end
endmodule
bind wsc_watchdog_ctrl wsc_watchdog_ctrl_properties u_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .core_in(core_in), .core_out(core_out), .port_out(port_out), .port_oe_n(port_oe_n));
`default_nettype wire
